// ==== design/fiap_ctrl.sv ====
// Design decisions made here: the Avalon-MM register port and the register offsets.
`timescale 1ns/1ps
`include "fiap_map.svh"


module fiap_ctrl
	import fiap_pkg::*;
#(
	parameter logic [1:0] VARIANT = `FIAP_VAR_BLOCK256 // Erase granularity
) (
	input  wire logic                  core_clk,        // System clock
	input  wire logic                  rstn,            // Async reset, active low
	input  wire logic [5:0]            avs_address,     // Byte address
	input  wire logic                  avs_read,        // Read request
	input  wire logic                  avs_write,       // Write request
	input  wire logic [31:0]           avs_writedata,   // Write data
	input  wire logic [3:0]            avs_byteenable,  // Byte lanes
	output logic [31:0]                avs_readdata,    // Read data
	output logic                       avs_waitrequest, // Stall
	input  wire logic                  slow_rc_osc,     // Slow RC oscillator
	output logic                       flash_req,       // Flash op pending
	output fiap_flash_cmd_t            flash_cmd,       // Flash op command
	input  wire logic                  flash_done,      // Flash op finished
	input  wire logic [15:0]           flash_rdata,     // Flash read data
	output logic                       cpu_halt,        // Processor stall
	output logic                       irq              // Interrupt level
);

	fiap_state_t state;          // Sequencer state
	logic        ack;            // Bus answer phase
	logic        unlocked;       // Write-unlocked flag
	logic [2:0]  op_sel;         // Flash operation select
	logic        write_go;       // Write/erase initiate
	logic        read_go;        // Read initiate
	logic        read_enable;    // Read enable
	logic [7:0]  addr_lower;     // Low address byte
	logic [6:0]  addr_upper;     // Upper address bits
	logic [7:0]  data_lo [4];    // Data word low bytes
	logic [7:0]  data_hi [4];    // Data word high bytes
	logic [2:0]  key_idx;        // Next key position
	fiap_irq_t   irq_status;     // Sticky events
	fiap_irq_t   irq_mask;       // Event enables
	logic [6:0]  upper_mask;     // Implemented upper bits
	logic [31:0] next_readdata;  // Read mux
	logic        wr_fire;        // Write takes effect
	logic        rd_fire;        // Read completes
	logic        arm_req;        // Unlock sequence start
	logic        key_wr;         // Data write while armed
	logic        key_match;      // Byte matches key
	logic        key_good;       // Right byte, right slot
	logic        expired;        // Unlock window over
	logic        unlock_fail;    // Attempt failed
	logic        unlock_ok;      // Attempt succeeded
	logic        op_modify;      // Write or erase selected
	logic        issue_ok;       // Flash op accepted
	logic        refuse;         // Flash op refused
	logic        done;           // Flash op complete
	logic [14:0] erase_addr;     // Block or page base
	fiap_irq_t   events;         // This cycle's events

	// Upper address bits kept for this variant
	assign upper_mask = (VARIANT == `FIAP_VAR_BLOCK256) ? `FIAP_UPPER_MASK_B256 :
		(VARIANT == `FIAP_VAR_PAGE32) ? `FIAP_UPPER_MASK_P32 : `FIAP_UPPER_MASK_P64;

	////////////////////////////////////////////////////////////////
	// Avalon handshake: one wait cycle, then answer
	assign avs_waitrequest = (avs_read || avs_write) && !ack;
	// Every register sits in byte lane 0
	assign wr_fire         = avs_write && ack && avs_byteenable[0];
	assign rd_fire         = avs_read && ack;

	// Answer phase and registered read data
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			ack          <= 1'b0;
			avs_readdata <= 32'h0000_0000;
		end else begin
			ack <= (avs_read || avs_write) && !ack;
			if (avs_read && !ack) begin
				avs_readdata <= next_readdata; // Stands at the accepting edge
			end
		end
	end

	// Read mux, unmapped reads as zero
	always_comb begin
		next_readdata = 32'h0000_0000;
		unique case (avs_address)
			`FIAP_OFF_CTRL:       next_readdata[7:0] = {unlocked, op_sel, state == FIAP_ST_ARMED,
				write_go, read_enable, read_go};
			`FIAP_OFF_ADDR_LOWER: next_readdata[7:0] = addr_lower;
			`FIAP_OFF_ADDR_UPPER: next_readdata[6:0] = addr_upper & upper_mask;
			`FIAP_OFF_IRQ_STATUS: next_readdata[3:0] = irq_status;
			`FIAP_OFF_IRQ_MASK:   next_readdata[3:0] = irq_mask;
			default: begin
				// Data words decoded by their stride
				for (int i = 0; i < 4; i++) begin
					if (avs_address == 6'(`FIAP_OFF_DATA0_LO + i * `FIAP_DATA_STRIDE)) begin
						next_readdata[7:0] = data_lo[i];
					end
					if (avs_address == 6'(`FIAP_OFF_DATA0_LO + i * `FIAP_DATA_STRIDE + `FIAP_HALF_STRIDE)) begin
						next_readdata[7:0] = data_hi[i];
					end
				end
			end
		endcase
	end

	////////////////////////////////////////////////////////////////
	// Unlock sequence decode
	// start on unlock code with arm set
	// both fields taken from one write
	assign arm_req = wr_fire && (avs_address == `FIAP_OFF_CTRL) && (state == FIAP_ST_IDLE)
		&& (avs_writedata[`FIAP_CTRL_OP_HI:`FIAP_CTRL_OP_LO] == FIAP_OP_UNLOCK)
		&& avs_writedata[`FIAP_CTRL_ARM];
	assign key_wr  = wr_fire && (state == FIAP_ST_ARMED)
		&& (avs_address >= `FIAP_OFF_DATA1_LO) && (avs_address <= `FIAP_OFF_DATA3_HI);
	// key slot order word1 low up to word3 high
	assign key_good = key_match && (avs_address == 6'(`FIAP_OFF_DATA1_LO + {key_idx, 2'b00}));

	// byte compared as it is written
	fiap_key_check u_key_check (
		.idx   (key_idx),
		.data  (avs_writedata[7:0]),
		.match (key_match)
	);

	fiap_timeout u_timeout (
		.core_clk    (core_clk),
		.rstn        (rstn),
		.run         (state == FIAP_ST_ARMED),
		.slow_rc_osc (slow_rc_osc),
		.expired     (expired)
	);

	assign unlock_fail = (state == FIAP_ST_ARMED) && (expired || (key_wr && !key_good));
	// last good byte before overflow unlocks
	assign unlock_ok   = (state == FIAP_ST_ARMED) && !expired && key_wr && key_good
		&& (key_idx == `FIAP_KEY_LAST);

	////////////////////////////////////////////////////////////////
	// Flash operation decode
	// write and erase modify, read reads
	assign op_modify = (op_sel == FIAP_OP_WRITE) || (op_sel == FIAP_OP_ERASE);
	assign issue_ok  = (state == FIAP_ST_IDLE) && ((write_go && unlocked && op_modify)
		|| (read_go && read_enable && (op_sel == FIAP_OP_READ)));
	// Refused go bits drop with no array request
	assign refuse    = (state != FIAP_ST_FLASH) && (write_go || read_go) && !issue_ok;
	// Completion only counts while an op is pending
	assign done      = (state == FIAP_ST_FLASH) && flash_done;

	// block chosen by upper bits only
	// page adds low bits 7..5 or 7..6
	always_comb begin
		unique case (VARIANT)
			`FIAP_VAR_PAGE32: erase_addr = {addr_upper & upper_mask, addr_lower[7:5], 5'h00};
			`FIAP_VAR_PAGE64: erase_addr = {addr_upper & upper_mask, addr_lower[7:6], 6'h00};
			default:          erase_addr = {addr_upper & upper_mask, 8'h00};
		endcase
	end

	////////////////////////////////////////////////////////////////
	// Sequencer state and key position
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			state   <= FIAP_ST_IDLE;
			key_idx <= 3'h0;
		end else begin
			unique case (state)
				FIAP_ST_IDLE: begin
					// Key position restarts for every attempt
					key_idx <= 3'h0;
					if (arm_req) begin
						state <= FIAP_ST_ARMED;
					end else if (issue_ok) begin
						state <= FIAP_ST_FLASH;
					end
				end
				FIAP_ST_ARMED: begin
					if (unlock_fail || unlock_ok) begin
						state <= FIAP_ST_IDLE;
					end else if (key_wr) begin
						key_idx <= key_idx + 3'h1;
					end
				end
				FIAP_ST_FLASH: begin
					// Array finish returns to idle
					if (flash_done) begin
						state <= FIAP_ST_IDLE;
					end
				end
				// Unused state code recovers to idle
				default: state <= FIAP_ST_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////
	// Control register bits
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			unlocked    <= 1'b0;
			op_sel      <= `FIAP_OP_RESET;
			write_go    <= 1'b0;
			read_go     <= 1'b0;
			read_enable <= 1'b0;
		end else begin
			if (wr_fire && (avs_address == `FIAP_OFF_CTRL)) begin
				// only a zero write touches the flag
				if (!avs_writedata[`FIAP_CTRL_UNLOCKED]) begin
					unlocked <= 1'b0;
				end
				op_sel      <= avs_writedata[`FIAP_CTRL_OP_HI:`FIAP_CTRL_OP_LO];
				read_enable <= avs_writedata[`FIAP_CTRL_READ_EN];
				if (avs_writedata[`FIAP_CTRL_WRITE_GO]) begin
					write_go <= 1'b1;
				end
				if (avs_writedata[`FIAP_CTRL_READ_GO]) begin
					read_go <= 1'b1;
				end
			end
			// success sets the flag, winning over a clear
			if (unlock_ok) begin
				unlocked <= 1'b1;
			end
			// hardware clears go bits at the end
			if (done || refuse) begin
				write_go <= 1'b0;
				read_go  <= 1'b0;
			end
		end
	end

	// processor stalled while a go bit stands
	assign cpu_halt = write_go || read_go;

	////////////////////////////////////////////////////////////////
	// Address and data word registers
	// four words, zero from reset
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			addr_lower <= `FIAP_BYTE_RESET;
			addr_upper <= 7'h00;
			for (int i = 0; i < 4; i++) begin
				data_lo[i] <= `FIAP_BYTE_RESET;
				data_hi[i] <= `FIAP_BYTE_RESET;
			end
		end else begin
			if (wr_fire && (avs_address == `FIAP_OFF_ADDR_LOWER)) begin
				addr_lower <= avs_writedata[7:0];
			end
			if (wr_fire && (avs_address == `FIAP_OFF_ADDR_UPPER)) begin
				addr_upper <= avs_writedata[6:0] & upper_mask;
			end
			for (int i = 0; i < 4; i++) begin
				if (wr_fire && (avs_address == 6'(`FIAP_OFF_DATA0_LO + i * `FIAP_DATA_STRIDE))) begin
					data_lo[i] <= avs_writedata[7:0];
				end
				if (wr_fire && (avs_address == 6'(`FIAP_OFF_DATA0_LO + i * `FIAP_DATA_STRIDE
					+ `FIAP_HALF_STRIDE))) begin
					data_hi[i] <= avs_writedata[7:0];
				end
			end
			// Read result lands in word 0
			if (done && (flash_cmd.op == FIAP_OP_READ)) begin
				data_lo[0] <= flash_rdata[7:0];
				data_hi[0] <= flash_rdata[15:8];
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// Flash command capture
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			flash_req <= 1'b0;
			flash_cmd <= '0;
		end else begin
			if (issue_ok) begin
				flash_req       <= 1'b1;
				flash_cmd.op    <= op_sel;
				flash_cmd.wdata <= {data_hi[0], data_lo[0]};
				// erase takes block or page base
				flash_cmd.addr  <= (op_sel == FIAP_OP_ERASE) ? erase_addr
					: {addr_upper & upper_mask, addr_lower};
			end else if (done) begin
				flash_req <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// Interrupt status, set wins over read-clear
	// Events packed in status bit order
	assign events = '{op_refused: refuse, op_done: done, unlock_fail: unlock_fail, unlock_ok: unlock_ok};

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			irq_status <= `FIAP_IRQ_RESET;
			irq_mask   <= `FIAP_IRQ_RESET;
		end else begin
			// Events of the clearing cycle survive the read
			if (rd_fire && (avs_address == `FIAP_OFF_IRQ_STATUS)) begin
				irq_status <= events;
			end else begin
				irq_status <= irq_status | events;
			end
			if (wr_fire && (avs_address == `FIAP_OFF_IRQ_MASK)) begin
				irq_mask <= avs_writedata[3:0];
			end
		end
	end

	// Level interrupt from unmasked sticky bits
	assign irq = |(irq_status & irq_mask);

endmodule

// ==== design/fiap_key_check.sv ====
`timescale 1ns/1ps
`include "fiap_map.svh"

module fiap_key_check
	import fiap_pkg::*;
(
	input  wire logic [2:0] idx,   // Position in the key
	input  wire logic [7:0] data,  // Byte written by software
	output logic            match  // Byte equals expected key byte
);

	logic [7:0] expect_byte; // Key byte for this position

	////////////////////////////////////////////////////////////////
	// Expected key byte lookup
	always_comb begin
		unique case (idx)
			3'h0: expect_byte = `FIAP_KEY0;
			3'h1: expect_byte = `FIAP_KEY1;
			3'h2: expect_byte = `FIAP_KEY2;
			3'h3: expect_byte = `FIAP_KEY3;
			3'h4: expect_byte = `FIAP_KEY4;
			3'h5: expect_byte = `FIAP_KEY5;
			default: expect_byte = 8'hFF; // Positions past the key never match
		endcase
	end

	assign match = (idx <= `FIAP_KEY_LAST) && (data == expect_byte);

endmodule

// ==== design/fiap_map.svh ====
`ifndef FIAP_MAP_SVH
`define FIAP_MAP_SVH

// Register byte offsets on the Avalon slave
`define FIAP_OFF_CTRL        6'h00
`define FIAP_OFF_ADDR_LOWER  6'h04
`define FIAP_OFF_ADDR_UPPER  6'h08
`define FIAP_OFF_DATA0_LO    6'h0C
`define FIAP_OFF_DATA1_LO    6'h14
`define FIAP_OFF_DATA3_HI    6'h28
`define FIAP_OFF_IRQ_STATUS  6'h2C
`define FIAP_OFF_IRQ_MASK    6'h30
`define FIAP_DATA_STRIDE     6'h08
`define FIAP_HALF_STRIDE     6'h04

// Control register field positions
`define FIAP_CTRL_UNLOCKED   7
`define FIAP_CTRL_OP_HI      6
`define FIAP_CTRL_OP_LO      4
`define FIAP_CTRL_ARM        3
`define FIAP_CTRL_WRITE_GO   2
`define FIAP_CTRL_READ_EN    1
`define FIAP_CTRL_READ_GO    0

// Reset values
`define FIAP_OP_RESET        3'h7
`define FIAP_BYTE_RESET      8'h00
`define FIAP_IRQ_RESET       4'h0

// Interrupt status bit positions
`define FIAP_IRQ_UNLOCK_OK   0
`define FIAP_IRQ_UNLOCK_FAIL 1
`define FIAP_IRQ_OP_DONE     2
`define FIAP_IRQ_OP_REFUSED  3

// Unlock key bytes in write order
`define FIAP_KEY0            8'h00
`define FIAP_KEY1            8'h04
`define FIAP_KEY2            8'h0D
`define FIAP_KEY3            8'h09
`define FIAP_KEY4            8'hC3
`define FIAP_KEY5            8'h40
`define FIAP_KEY_LAST        3'h5

// Unlock window, counted in slow RC oscillator ticks (longest time rounds down)
`define FIAP_UNLOCK_TIMEOUT_US 300
`define FIAP_SLOW_RC_KHZ       32
`define FIAP_UNLOCK_TICKS      ((`FIAP_UNLOCK_TIMEOUT_US * `FIAP_SLOW_RC_KHZ) / 1000)

// Erase granularity per variant
`define FIAP_VAR_BLOCK256    2'h0
`define FIAP_VAR_PAGE32      2'h1
`define FIAP_VAR_PAGE64      2'h2
`define FIAP_UPPER_MASK_B256 7'h0F
`define FIAP_UPPER_MASK_P32  7'h1F
`define FIAP_UPPER_MASK_P64  7'h3F

`endif

// ==== design/fiap_pkg.sv ====
package fiap_pkg;

	// Flash operation select codes
	typedef enum logic [2:0] {
		FIAP_OP_WRITE  = 3'b000,
		FIAP_OP_ERASE  = 3'b001,
		FIAP_OP_READ   = 3'b011,
		FIAP_OP_UNLOCK = 3'b110
	} fiap_op_t;

	// Sequencer states
	typedef enum logic [1:0] {
		FIAP_ST_IDLE  = 2'b00,
		FIAP_ST_ARMED = 2'b01,
		FIAP_ST_FLASH = 2'b10
	} fiap_state_t;

	// Command to the flash array
	typedef struct packed {
		logic [2:0]  op;
		logic [14:0] addr;
		logic [15:0] wdata;
	} fiap_flash_cmd_t;

	// Interrupt events
	typedef struct packed {
		logic op_refused;
		logic op_done;
		logic unlock_fail;
		logic unlock_ok;
	} fiap_irq_t;

endpackage

// ==== design/fiap_timeout.sv ====
`timescale 1ns/1ps
`include "fiap_map.svh"

module fiap_timeout
	import fiap_pkg::*;
(
	input  wire logic core_clk,    // System clock
	input  wire logic rstn,        // Async reset, active low
	input  wire logic run,         // Window open while high
	input  wire logic slow_rc_osc, // Slow RC oscillator level
	output logic      expired      // Window overflowed
);

	logic       rc_prev; // Last oscillator level
	logic [7:0] ticks;   // Oscillator edges seen

	////////////////////////////////////////////////////////////////
	// Count slow oscillator rising edges while the window is open
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			rc_prev <= 1'b0;
			ticks   <= 8'h00;
		end else begin
			rc_prev <= slow_rc_osc;
			if (!run) begin
				ticks <= 8'h00;             // Idle window restarts
			end else if (slow_rc_osc && !rc_prev && !expired) begin
				ticks <= ticks + 8'h01;     // One oscillator tick
			end
		end
	end

	// Overflow once the full tick count is reached
	assign expired = run && (ticks >= 8'(`FIAP_UNLOCK_TICKS));

endmodule

// ==== dv/fiap_ctrl_monitor.sv ====
`timescale 1ns/1ps
//////////////////////////////////////////////////
// Port checker for the programming controller
module fiap_ctrl_monitor
	import fiap_pkg::*;
#(
	parameter logic [1:0] VARIANT = 2'h0 // Erase size
) (
	input wire logic            core_clk,        // Clock
	input wire logic            rstn,            // Reset, low
	input wire logic [5:0]      avs_address,     // Address
	input wire logic            avs_read,        // Read
	input wire logic            avs_write,       // Write
	input wire logic [31:0]     avs_writedata,   // Wdata
	input wire logic [3:0]      avs_byteenable,  // Lanes
	input wire logic [31:0]     avs_readdata,    // Rdata
	input wire logic            avs_waitrequest, // Stall
	input wire logic            slow_rc_osc,     // Tick
	input wire logic            flash_req,       // Pending
	input wire fiap_flash_cmd_t flash_cmd,       // Command
	input wire logic            flash_done,      // Done
	input wire logic [15:0]     flash_rdata,     // Array data
	input wire logic            cpu_halt,        // Stall
	input wire logic            irq              // Interrupt
);
	// Address bits an erase must leave clear
	localparam logic [14:0] ERASE_ZERO = (VARIANT == 2'h0) ? 15'h70FF : (VARIANT == 2'h1) ? 15'h601F : 15'h403F;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rstn);
	sequence s_req_start;
		$rose(avs_read || avs_write);
	endsequence
	sequence s_one_wait;
		avs_waitrequest ##1 !avs_waitrequest;
	endsequence
	property p_bus_wait;
		s_req_start |-> s_one_wait;
	endproperty
	property p_unmapped;
		avs_read && !avs_waitrequest && avs_address > 6'h30 |-> avs_readdata == 32'h0;
	endproperty
	property p_rd_width;
		avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h0;
	endproperty
	property p_req_after_halt;
		$rose(flash_req) |-> $past(cpu_halt) && cpu_halt;
	endproperty
	property p_cmd_hold;
		flash_req && !flash_done |=> flash_req && $stable(flash_cmd);
	endproperty
	property p_done_clear;
		flash_req && flash_done |=> !flash_req && !cpu_halt;
	endproperty
	property p_op_legal;
		flash_req |-> flash_cmd.op inside {FIAP_OP_WRITE, FIAP_OP_ERASE, FIAP_OP_READ};
	endproperty
	property p_erase_addr;
		flash_req && flash_cmd.op == FIAP_OP_ERASE |-> (flash_cmd.addr & ERASE_ZERO) == 15'h0;
	endproperty
	property p_mask_off;
		avs_write && !avs_waitrequest && avs_address == 6'h30 && avs_byteenable[0] && avs_writedata[3:0] == 4'h0
			|=> !irq;
	endproperty
	a_bus_wait: assert property (p_bus_wait) else $error("bus wait not one cycle");
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
	a_rd_width: assert property (p_rd_width) else $error("read upper bits set");
	a_req_after_halt: assert property (p_req_after_halt) else $error("op without stall");
	a_cmd_hold: assert property (p_cmd_hold) else $error("command moved while pending");
	a_done_clear: assert property (p_done_clear) else $error("go not cleared at done");
	a_op_legal: assert property (p_op_legal) else $error("reserved op issued");
	a_erase_addr: assert property (p_erase_addr) else $error("erase address bits");
	a_mask_off: assert property (p_mask_off) else $error("masked interrupt high");
endmodule
bind fiap_ctrl fiap_ctrl_monitor #(.VARIANT(VARIANT)) u_mon (
	.core_clk(core_clk), .rstn(rstn), .avs_address(avs_address), .avs_read(avs_read),
	.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
	.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .slow_rc_osc(slow_rc_osc),
	.flash_req(flash_req), .flash_cmd(flash_cmd), .flash_done(flash_done),
	.flash_rdata(flash_rdata), .cpu_halt(cpu_halt), .irq(irq)
);

// ==== dv/fiap_ctrl_test.sv ====
`timescale 1ns/1ps
module fiap_ctrl_test
	import fiap_pkg::*;
;
	logic            core_clk = 1'b0;          // Clock
	logic            rstn = 1'b0;              // Reset, low
	logic [5:0]      avs_address = 6'h00;      // Address
	logic            avs_read = 1'b0;          // Read
	logic            avs_write = 1'b0;         // Write
	logic [31:0]     avs_writedata = 32'h0;    // Wdata
	logic [3:0]      avs_byteenable = 4'hF;    // Lanes
	logic [31:0]     avs_readdata;             // Rdata
	logic            avs_waitrequest;          // Stall
	logic            slow_rc_osc = 1'b0;       // Tick
	logic            flash_req;                // Pending
	fiap_flash_cmd_t flash_cmd;                // Command
	logic            flash_done;               // Done
	logic [15:0]     flash_rdata;              // Array data
	logic            cpu_halt;                 // Stall
	logic            irq;                      // Interrupt
	logic [3:0]      lat = 4'h1;               // Array latency
	logic [31:0]     lfsr = 32'h2F5A73BE;      // Random state
	logic [7:0]      rd;                       // Read byte
	int              err_count = 0;            // Mismatches
	int              tests_run = 0;            // Compares
	fiap_flash_cmd_t exp_q[$];                 // Expected ops
	fiap_flash_cmd_t e;                        // Current op
	logic [7:0]      key [6] = '{8'h00, 8'h04, 8'h0D, 8'h09, 8'hC3, 8'h40}; // Key
	fiap_ctrl #(.VARIANT(2'h0)) dut (
		.core_clk(core_clk), .rstn(rstn), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .slow_rc_osc(slow_rc_osc),
		.flash_req(flash_req), .flash_cmd(flash_cmd), .flash_done(flash_done),
		.flash_rdata(flash_rdata), .cpu_halt(cpu_halt), .irq(irq)
	);
	fiap_flash_model #(.WORDS(256)) u_flash (
		.core_clk(core_clk), .rstn(rstn), .flash_req(flash_req), .flash_cmd(flash_cmd),
		.lat(lat), .flash_done(flash_done), .flash_rdata(flash_rdata)
	);
	// 200 MHz clock
	always #2.5 core_clk = ~core_clk;
	//////////////////////////////////////////////////
	function automatic logic [31:0] next_rand(input logic [31:0] s);
		next_rand = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic complete_run;
		$display("Compares %0d, errors %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic chk(input logic [33:0] seen, input logic [33:0] exp, input string what);
		tests_run++;
		if (seen !== exp) begin
			err_count++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// Avalon cycle, held until waitrequest is low at an edge
	task automatic bus(input logic w, input logic [5:0] a, input logic [7:0] d, input logic [3:0] be);
		int n;
		n = 0;
		@(posedge core_clk);
		avs_read <= !w;
		avs_write <= w;
		avs_address <= a;
		avs_writedata <= {24'h0, d};
		avs_byteenable <= be;
		// Waitrequest sampled at each rising edge, release right after it is low
		do begin
			@(posedge core_clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 50);
		if (n >= 50) begin
			err_count++;
			complete_run();
		end
		rd = avs_readdata[7:0];
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask
	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		bus(1'b1, a, d, 4'hF);
	endtask
	task automatic rdc(input logic [5:0] a, input logic [7:0] x);
		bus(1'b0, a, 8'h00, 4'hF);
		chk(rd, x, "register");
	endtask
	task automatic stat(input logic [7:0] x);
		// Let a mask write of the edge before settle
		@(negedge core_clk);
		chk(irq, x != 8'h00, "irq");
		rdc(6'h2C, x);
		@(negedge core_clk);
		chk(irq, 1'b0, "irq_clear");
	endtask
	task automatic tick(input int n);
		repeat (n) begin
			@(posedge core_clk) slow_rc_osc <= 1'b1;
			@(posedge core_clk) slow_rc_osc <= 1'b0;
		end
	endtask
	// Start an op and follow it to completion
	task automatic run_op(input logic [7:0] c);
		int n;
		n = 0;
		wr(6'h00, c);
		while (flash_req !== 1'b1 && n < 20) begin
			@(negedge core_clk);
			n++;
		end
		if (n >= 20) begin
			err_count++;
			complete_run();
		end
		e = exp_q.pop_front();
		chk(cpu_halt, 1'b1, "cpu_halt");
		chk({flash_cmd.op, flash_cmd.addr}, {e.op, e.addr}, "flash_cmd");
		if (e.op == FIAP_OP_WRITE) chk(flash_cmd.wdata, e.wdata, "flash_wdata");
		while (flash_req === 1'b1 && n < 60) begin
			@(negedge core_clk);
			n++;
		end
		if (n >= 60) begin
			err_count++;
			complete_run();
		end
		chk(cpu_halt, 1'b0, "cpu_halt_end");
	endtask
	//////////////////////////////////////////////////
	// Main sequence
	initial begin
		repeat (2) @(posedge core_clk);
		rstn <= 1'b1;
		@(posedge core_clk);
		rdc(6'h00, 8'h70);
		for (int i = 1; i < 13; i++) rdc(6'(i * 4), 8'h00);
		wr(6'h34, 8'hFF);
		rdc(6'h34, 8'h00);
		for (int i = 3; i < 11; i++) begin
			lfsr = next_rand(lfsr);
			wr(6'(i * 4), lfsr[7:0]);
			rdc(6'(i * 4), lfsr[7:0]);
		end
		bus(1'b1, 6'h28, ~lfsr[7:0], 4'hE);
		rdc(6'h28, lfsr[7:0]);
		wr(6'h30, 8'h0F);
		wr(6'h00, 8'h04);
		repeat (3) @(negedge core_clk);
		chk(flash_req, 1'b0, "locked_write");
		rdc(6'h00, 8'h00);
		stat(8'h08);
		wr(6'h30, 8'h00);
		wr(6'h00, 8'h68);
		rdc(6'h00, 8'h68);
		wr(6'h14, key[0]);
		wr(6'h18, 8'h05);
		rdc(6'h00, 8'h60);
		@(negedge core_clk);
		chk(irq, 1'b0, "irq_masked");
		wr(6'h30, 8'h0F);
		stat(8'h02);
		wr(6'h00, 8'h68);
		for (int i = 0; i < 3; i++) wr(6'(20 + 4 * i), key[i]);
		tick(8);
		rdc(6'h00, 8'h68);
		tick(1);
		rdc(6'h00, 8'h60);
		stat(8'h02);
		wr(6'h00, 8'h68);
		for (int i = 0; i < 6; i++) begin
			tick(i == 0 ? 3 : 1);
			wr(6'(20 + 4 * i), key[i]);
		end
		rdc(6'h00, 8'hE0);
		stat(8'h01);
		lfsr = next_rand(lfsr);
		wr(6'h08, lfsr[7:0]);
		wr(6'h04, lfsr[15:8]);
		rdc(6'h08, {4'h0, lfsr[3:0]});
		lat = 4'h6;
		exp_q.push_back('{FIAP_OP_ERASE, {3'h0, lfsr[3:0], 8'h00}, 16'h0});
		run_op(8'h94);
		rdc(6'h00, 8'h90);
		stat(8'h04);
		wr(6'h0C, lfsr[23:16]);
		wr(6'h10, lfsr[31:24]);
		lat = 4'h0;
		exp_q.push_back('{FIAP_OP_WRITE, {3'h0, lfsr[3:0], lfsr[15:8]}, lfsr[31:16]});
		run_op(8'h84);
		stat(8'h04);
		wr(6'h0C, 8'h00);
		wr(6'h10, 8'h00);
		exp_q.push_back('{FIAP_OP_READ, {3'h0, lfsr[3:0], lfsr[15:8]}, 16'h0});
		run_op(8'hB3);
		rdc(6'h0C, lfsr[23:16]);
		rdc(6'h10, lfsr[31:24]);
		rdc(6'h00, 8'hB2);
		stat(8'h04);
		wr(6'h00, 8'h00);
		rdc(6'h00, 8'h00);
		wr(6'h00, 8'h80);
		rdc(6'h00, 8'h00);
		wr(6'h00, 8'h84);
		repeat (3) @(negedge core_clk);
		chk(flash_req, 1'b0, "relocked_write");
		stat(8'h08);
		wr(6'h00, 8'h31);
		rdc(6'h00, 8'h30);
		stat(8'h08);
		complete_run();
	end
endmodule

// ==== dv/fiap_flash_model.sv ====
`timescale 1ns/1ps
//////////////////////////////////////////////////
// Behavioural program flash array
module fiap_flash_model
	import fiap_pkg::*;
#(
	parameter int WORDS = 256 // Words per erase
) (
	input  wire logic            core_clk,   // Clock
	input  wire logic            rstn,       // Reset, low
	input  wire logic            flash_req,  // Pending
	input  wire fiap_flash_cmd_t flash_cmd,  // Command
	input  wire logic [3:0]      lat,        // Busy cycles
	output logic                 flash_done, // Done pulse
	output logic [15:0]          flash_rdata // Read data
);
	logic [15:0] mem [int]; // Programmed words
	logic [15:0] rd_word;   // Last read
	int          cnt;       // Busy count
	// Bus shows inverse of last word outside done
	assign flash_rdata = flash_done ? rd_word : ~rd_word;
	// One op at a time, done after lat cycles
	always @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			cnt        <= 0;
			flash_done <= 1'b0;
			rd_word    <= 16'h0000;
		end else begin
			flash_done <= 1'b0;
			if (flash_req && !flash_done) begin
				if (cnt < lat) begin
					cnt <= cnt + 1;
				end else begin
					cnt        <= 0;
					flash_done <= 1'b1;
					case (flash_cmd.op)
						FIAP_OP_ERASE: for (int i = 0; i < WORDS; i++) mem.delete(int'(flash_cmd.addr) + i);
						FIAP_OP_WRITE: mem[int'(flash_cmd.addr)] = flash_cmd.wdata;
						FIAP_OP_READ: rd_word <= mem.exists(int'(flash_cmd.addr)) ? mem[int'(flash_cmd.addr)] : 16'hFFFF;
						default: ;
					endcase
				end
			end
		end
	end
endmodule
